// [tcc_capture_compare.sv]
// Capture channel and compare channel with their register port
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module tcc_capture_compare (
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   // Register port
   input  wire logic [2:0]  ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [15:0] RDATA,
   // Time bases and power state
   input  wire logic [15:0] TMR_FIRST,
   input  wire logic [15:0] TMR_SECOND,
   input  wire logic        CPU_IDLE,
   input  wire logic        CPU_SLEEP,
   // Capture side
   input  wire logic        CAP_PIN,
   output logic             CAP_IRQ,
   output logic             WAKE,
   // Compare side
   input  wire logic        FAULT_PIN,
   output logic             CMP_OUT,
   output logic             CMP_OE_N,
   output logic             CMP_IRQ
);
   import tcc_pkg::*;

   // ===========================================================
   // State
   typedef struct packed {
      logic          cap_sidl;
      logic          cap_tsel;
      logic [1:0]    cap_ici;
      tcc_cap_mode_t cap_mode;
      logic          cap_ovf;
      logic [3:0]    pre;
      logic [1:0]    icnt;
      logic          cmp_sidl;
      logic          cmp_tsel;
      tcc_cmp_mode_t cmp_mode;
      tcc_cmp_mode_t cmp_prev;
      logic          cmp_fault;
      logic          cmp_done;
      logic [15:0]   pri;
      logic [15:0]   sec;
      logic          cmp_out;
      logic          cmp_oe_n;
      logic          cmp_irq;
      logic          cap_irq;
      logic          wake;
      logic [15:0]   rdata;
   } tcc_st_t;

   tcc_st_t st_q;
   tcc_st_t st_d;

   logic        cap_rise;
   logic        cap_fall;
   logic        flt_fall;
   logic        fifo_full;
   logic        fifo_empty;
   logic [15:0] fifo_head;
   logic        cap_push;
   logic        cap_pop;
   logic        cap_ev;
   logic        cap_halt;
   logic        cmp_halt;
   logic [15:0] cap_time;
   logic [15:0] cmp_time;
   logic        m_pri;
   logic        m_sec;
   logic        sleepy;

   // ===========================================================
   // Pin conditioning and capture queue
   tcc_sync u_cap_sync (
      .clk  (CLK_SYS),
      .rst  (RST),
      .din  (CAP_PIN),
      .lvl  (),
      .rise (cap_rise),
      .fall (cap_fall)
   );

   tcc_sync u_flt_sync (
      .clk  (CLK_SYS),
      .rst  (RST),
      .din  (FAULT_PIN),
      .lvl  (),
      .rise (),
      .fall (flt_fall)
   );

   tcc_fifo u_fifo (
      .clk   (CLK_SYS),
      .rst   (RST),
      .push  (cap_push),
      .wdata (cap_time),
      .pop   (cap_pop),
      .head  (fifo_head),
      .full  (fifo_full),
      .empty (fifo_empty)
   );

   // Picks a time base; shared by both channels
   function automatic logic [15:0] pick_tmr(input logic sel, input logic [15:0] a, input logic [15:0] b);
      pick_tmr = sel ? b : a;
   endfunction

   // ===========================================================
   // Capture event decode
   always_comb begin
      sleepy   = CPU_IDLE | CPU_SLEEP;
      cap_halt = CPU_IDLE & st_q.cap_sidl;
      cap_time = pick_tmr(st_q.cap_tsel, TMR_FIRST, TMR_SECOND); // R2
      cap_ev   = 1'b0;
      // Mode 000, 110 and 111 record nothing
      case (st_q.cap_mode) // R24
         CAP_BOTH:  cap_ev = cap_rise | cap_fall; // R3
         CAP_FALL:  cap_ev = cap_fall; // R3
         CAP_RISE:  cap_ev = cap_rise; // R3
         CAP_PRE4:  cap_ev = cap_rise && st_q.pre[1:0] == PRE4_LAST[1:0]; // R4
         CAP_PRE16: cap_ev = cap_rise && st_q.pre == PRE16_LAST; // R4
         default:   cap_ev = 1'b0;
      endcase
      if (cap_halt) begin
         cap_ev = 1'b0;
      end
      cap_push = cap_ev & ~fifo_full; // R1
      cap_pop  = RD && ADDR == ADR_CAP_BUF && !fifo_empty;
   end

   // Compare match decode
   always_comb begin
      cmp_time = pick_tmr(st_q.cmp_tsel, TMR_FIRST, TMR_SECOND); // R10
      m_pri    = (cmp_time == st_q.pri);
      m_sec    = (cmp_time == st_q.sec);
      cmp_halt = CPU_IDLE & st_q.cmp_sidl; // R22
   end

   // ===========================================================
   // Next-state logic for both channels and the register port
   always_comb begin
      st_d         = st_q;
      st_d.cap_irq = 1'b0;
      st_d.cmp_irq = 1'b0;
      st_d.wake    = 1'b0;
      st_d.rdata   = 16'h0000;

      // Capture: prescaler only counts rising edges in prescaled modes
      if (!cap_halt && cap_rise && (st_q.cap_mode == CAP_PRE4 || st_q.cap_mode == CAP_PRE16)) begin
         st_d.pre = st_q.pre + 4'h1; // R4
         if (st_q.cap_mode == CAP_PRE4 && st_q.pre[1:0] == PRE4_LAST[1:0]) begin
            st_d.pre = 4'h0;
         end
      end
      // Interrupt after the programmed number of stored captures
      if (cap_push) begin
         if (st_q.icnt == st_q.cap_ici) begin
            st_d.cap_irq = 1'b1; // R6
            st_d.icnt    = 2'h0;
         end else begin
            st_d.icnt = st_q.icnt + 2'h1;
         end
      end
      // Overflow clears only when the channel is turned off
      if (st_q.cap_mode == CAP_OFF) begin
         st_d.cap_ovf = 1'b0;
      end
      if (cap_ev && fifo_full) begin
         st_d.cap_ovf = 1'b1; // R7
      end
      if (cap_ev && sleepy) begin
         st_d.wake = 1'b1; // R9
      end
      // Wake-only mode ignores every other setting
      if (st_q.cap_mode == CAP_WAKE && cap_rise && sleepy) begin
         st_d.cap_irq = 1'b1; // R5
         st_d.wake    = 1'b1; // R9
      end

      // Compare: entering a mode sets its initial pin level
      if (st_q.cmp_mode != st_q.cmp_prev) begin
         st_d.cmp_prev = st_q.cmp_mode;
         st_d.cmp_done = 1'b0;
         if (st_q.cmp_mode != CMP_PWM_FLT) begin
            st_d.cmp_fault = 1'b0; // R20
         end
         case (st_q.cmp_mode)
            CMP_SET_HI:    st_d.cmp_out = 1'b0; // R12
            CMP_SET_LO:    st_d.cmp_out = 1'b1; // R13
            CMP_TOGGLE:    st_d.cmp_out = st_q.cmp_out; // R14
            CMP_ONE_PULSE: st_d.cmp_out = 1'b0; // R15
            CMP_PULSES:    st_d.cmp_out = 1'b0; // R17
            CMP_PWM:       st_d.cmp_out = (st_q.pri != 16'h0000); // R18
            CMP_PWM_FLT:   st_d.cmp_out = (st_q.pri != 16'h0000); // R19
            default:       st_d.cmp_out = 1'b0; // R21
         endcase
      end else if (!cmp_halt) begin // R22
         case (st_q.cmp_mode) // R11
            CMP_SET_HI: begin
               if (m_pri && !st_q.cmp_out) begin
                  st_d.cmp_out = 1'b1; // R12
                  st_d.cmp_irq = 1'b1;
               end
            end
            CMP_SET_LO: begin
               if (m_pri && st_q.cmp_out) begin
                  st_d.cmp_out = 1'b0; // R13
                  st_d.cmp_irq = 1'b1;
               end
            end
            CMP_TOGGLE: begin
               if (m_pri) begin
                  st_d.cmp_out = ~st_q.cmp_out; // R14
                  st_d.cmp_irq = 1'b1;
               end
            end
            CMP_ONE_PULSE, CMP_PULSES: begin
               // One-shot stops after its first falling edge
               if (!st_q.cmp_done || st_q.cmp_mode == CMP_PULSES) begin
                  if (m_sec && st_q.cmp_out) begin
                     st_d.cmp_out  = 1'b0; // R16
                     st_d.cmp_irq  = 1'b1; // R15 R17
                     st_d.cmp_done = (st_q.cmp_mode == CMP_ONE_PULSE);
                  end else if (m_pri) begin
                     st_d.cmp_out = 1'b1; // R16
                  end
               end
            end
            CMP_PWM, CMP_PWM_FLT: begin
               // Period restarts at timer zero; duty ends at primary match
               if (m_pri) begin
                  st_d.cmp_out = 1'b0;
               end else if (cmp_time == 16'h0000) begin
                  st_d.cmp_out = (st_q.pri != 16'h0000); // R18
               end
               if (st_q.cmp_mode == CMP_PWM_FLT) begin
                  if (flt_fall) begin
                     st_d.cmp_fault = 1'b1; // R20
                     st_d.cmp_irq   = 1'b1; // R19
                  end
                  if (flt_fall || st_q.cmp_fault) begin
                     st_d.cmp_out = 1'b0; // R19
                  end
               end
            end
            default: begin
               st_d.cmp_out = 1'b0; // R21
            end
         endcase
      end
      st_d.cmp_oe_n = (st_d.cmp_mode == CMP_OFF); // R21

      // Register writes; status bits are read-only
      if (WR) begin
         case (ADDR)
            ADR_CAP_CTL: begin
               st_d.cap_sidl = WDATA[CAP_SIDL_BIT];
               st_d.cap_tsel = WDATA[CAP_TSEL_BIT]; // R2
               st_d.cap_ici  = WDATA[CAP_ICI_LSB +: 2]; // R6
               st_d.cap_mode = tcc_cap_mode_t'(WDATA[MODE_LSB +: 3]);
               st_d.pre      = 4'h0;
               st_d.icnt     = 2'h0;
            end
            ADR_CMP_CTL: begin
               // Timer is expected to be stopped around this write
               st_d.cmp_sidl = WDATA[CMP_SIDL_BIT]; // R23
               st_d.cmp_tsel = WDATA[CMP_TSEL_BIT]; // R10
               st_d.cmp_mode = tcc_cmp_mode_t'(WDATA[MODE_LSB +: 3]);
            end
            ADR_CMP_PRI: st_d.pri = WDATA;
            ADR_CMP_SEC: st_d.sec = WDATA;
            default:     st_d.pri = st_q.pri;
         endcase
      end

      // Read data stands only in the cycle after the strobe
      if (RD) begin
         case (ADDR)
            ADR_CAP_CTL: begin
               st_d.rdata[CAP_SIDL_BIT]     = st_q.cap_sidl;
               st_d.rdata[CAP_TSEL_BIT]     = st_q.cap_tsel;
               st_d.rdata[CAP_ICI_LSB +: 2] = st_q.cap_ici;
               st_d.rdata[CAP_OVF_BIT]      = st_q.cap_ovf; // R7
               st_d.rdata[CAP_BNE_BIT]      = ~fifo_empty; // R8
               st_d.rdata[MODE_LSB +: 3]    = st_q.cap_mode;
            end
            ADR_CAP_BUF: st_d.rdata = fifo_empty ? VAL_RST : fifo_head; // R8
            ADR_CMP_CTL: begin
               st_d.rdata[CMP_SIDL_BIT]  = st_q.cmp_sidl;
               st_d.rdata[CMP_FLT_BIT]   = st_q.cmp_fault; // R20
               st_d.rdata[CMP_TSEL_BIT]  = st_q.cmp_tsel;
               st_d.rdata[MODE_LSB +: 3] = st_q.cmp_mode;
            end
            ADR_CMP_PRI: st_d.rdata = st_q.pri;
            ADR_CMP_SEC: st_d.rdata = st_q.sec;
            default:     st_d.rdata = 16'h0000;
         endcase
      end
   end

   // ===========================================================
   // State register
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         st_q          <= '0;
         st_q.cmp_oe_n <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign RDATA    = st_q.rdata;
   assign CAP_IRQ  = st_q.cap_irq;
   assign WAKE     = st_q.wake;
   assign CMP_OUT  = st_q.cmp_out;
   assign CMP_OE_N = st_q.cmp_oe_n;
   assign CMP_IRQ  = st_q.cmp_irq;

   // ===========================================================
   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   property p_cap_value;
      cap_push |-> cap_time == (st_q.cap_tsel ? TMR_SECOND : TMR_FIRST);
   endproperty
   a_cap_value: assert property (p_cap_value) else $error("capture value not from selected timer"); // R1

   property p_fall_only;
      st_q.cap_mode == CAP_FALL && cap_rise && !cap_fall |-> !cap_push;
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("rising edge captured in falling mode"); // R3

   property p_pre4;
      st_q.cap_mode == CAP_PRE4 && cap_push |-> st_q.pre[1:0] == 2'h3 && cap_rise;
   endproperty
   a_pre4: assert property (p_pre4) else $error("capture not on fourth rising edge"); // R4

   property p_ici;
      cap_push && st_q.icnt == st_q.cap_ici && !WR |=> CAP_IRQ && st_q.icnt == 2'h0;
   endproperty
   a_ici: assert property (p_ici) else $error("capture interrupt count wrong"); // R6

   property p_ovf;
      cap_ev && fifo_full |=> st_q.cap_ovf && (fifo_full || $past(cap_pop));
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // R7

   property p_bne;
      RD && ADDR == ADR_CAP_CTL |=> RDATA[CAP_BNE_BIT] != $past(fifo_empty);
   endproperty
   a_bne: assert property (p_bne) else $error("buffer-not-empty bit wrong"); // R8

   property p_set_hi;
      st_q.cmp_mode == CMP_SET_HI && st_q.cmp_prev == CMP_SET_HI && !cmp_halt && m_pri && !CMP_OUT
         |=> CMP_OUT && CMP_IRQ;
   endproperty
   a_set_hi: assert property (p_set_hi) else $error("mode 001 match did not drive high"); // R12

   property p_toggle;
      st_q.cmp_mode == CMP_TOGGLE && st_q.cmp_prev == CMP_TOGGLE && !cmp_halt && m_pri
         |=> CMP_OUT != $past(CMP_OUT) ##1 !CMP_IRQ || $past(m_pri);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle mode did not toggle"); // R14

   property p_fault;
      st_q.cmp_mode == CMP_PWM_FLT && st_q.cmp_prev == CMP_PWM_FLT && !cmp_halt && flt_fall
         |=> st_q.cmp_fault && !CMP_OUT && CMP_IRQ;
   endproperty
   a_fault: assert property (p_fault) else $error("fault not handled"); // R19

   property p_off;
      st_q.cmp_mode == CMP_OFF && !WR |=> CMP_OE_N && !CMP_IRQ;
   endproperty
   a_off: assert property (p_off) else $error("disabled compare drives pin"); // R21

   property p_halt;
      cmp_halt && st_q.cmp_mode == st_q.cmp_prev && !WR |=> $stable(CMP_OUT);
   endproperty
   a_halt: assert property (p_halt) else $error("compare moved while halted"); // R22

   c_overflow: cover property (cap_ev && fifo_full);
   c_pulse:    cover property (st_q.cmp_mode == CMP_PULSES && CMP_IRQ);
   c_fault:    cover property (st_q.cmp_fault);
   c_wake:     cover property (st_q.cap_mode == CAP_WAKE && WAKE);
endmodule

// [tcc_capture_compare_bench.sv]
// Self-checking bench for the capture and compare unit
`timescale 1ns/1ps
module tcc_capture_compare_bench;
   import tcc_pkg::*;
   logic        clk, rst, wr, rd, idle, sleep, run, sel_b, cnt_en, last;
   logic        cap_pin, fault_pin, cap_irq, wake, cmp_out, oe_n, cmp_irq, pad;
   logic [2:0]  addr;
   logic [15:0] wdata, rdata, t1, t2, d;
   int          n_errors = 0, checks = 0, rises, falls, c_irqs = 0, p_irqs, wakes = 0, n;
   int          npul[5] = '{2, 2, 2, 8, 16};
   int          ecap[5] = '{4, 2, 2, 2, 1};
   int          cm[7] = '{1, 2, 1, 3, 4, 5, 6};
   int          cs[7] = '{0, 1, 0, 0, 1, 0, 0};
   int          ci[7] = '{0, 0, 1, 0, 0, 0, 0};
   int          er[7] = '{1, 0, 0, 1, 1, 2, 2};
   int          ef[7] = '{0, 1, 0, 1, 1, 2, 2};
   int          ei[7] = '{1, 1, 0, 2, 1, 2, 0};

   tcc_capture_compare dut (.CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .TMR_FIRST(t1), .TMR_SECOND(t2), .CPU_IDLE(idle), .CPU_SLEEP(sleep),
      .CAP_PIN(cap_pin), .CAP_IRQ(cap_irq), .WAKE(wake), .FAULT_PIN(fault_pin), .CMP_OUT(cmp_out),
      .CMP_OE_N(oe_n), .CMP_IRQ(cmp_irq));
   tcc_partner p (.clk(clk), .cap_pin(cap_pin), .fault_pin(fault_pin), .cmp_out(cmp_out),
      .cmp_oe_n(oe_n), .pad(pad));

   // ======================================
   // Clock, time base and counters
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Only the selected base runs, so a wrong select never matches
   always @(posedge clk) begin
      if (run && sel_b) t2 <= (t2 == 16'h001f) ? 16'h0000 : t2 + 16'h0001;
      if (run && !sel_b) t1 <= (t1 == 16'h001f) ? 16'h0000 : t1 + 16'h0001;
   end

   // Sampled mid-cycle, clear of the launching edge
   always @(negedge clk) begin
      if (cap_irq === 1'b1) c_irqs++;
      if (wake === 1'b1) wakes++;
      if (cnt_en && cmp_irq === 1'b1) p_irqs++;
      if (cnt_en && cmp_out === 1'b1 && last === 1'b0) rises++;
      if (cnt_en && cmp_out === 1'b0 && last === 1'b1) falls++;
      last = cmp_out;
   end

   // ======================================
   // Tasks
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [15:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd_chk(input string what, input logic [2:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      if (what != "") chk(what, exp, d);
      // Hand back on a rising edge so callers drive inputs there
      @(posedge clk);
   endtask

   task automatic drain(input logic [15:0] exp, output int cnt);
      cnt = 0;
      repeat (8) begin
         rd_chk("", ADR_CAP_CTL, 16'h0000);
         if (d[CAP_BNE_BIT] !== 1'b1) break;
         rd_chk("capture value", ADR_CAP_BUF, exp);
         cnt++;
      end
   endtask

   // A hang ends the run as a failure
   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end

   // ======================================
   // Main sequence
   initial begin
      {rst, wr, rd, idle, sleep, run, sel_b, cnt_en, last} = 9'h100;
      {addr, wdata, t1, t2} = '0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd_chk("cap ctl reset", ADR_CAP_CTL, CTL_RST);
      rd_chk("cmp ctl reset", ADR_CMP_CTL, CTL_RST);
      chk("released pin", 16'h0001, {15'h0, pad});
      wr_reg(ADR_CAP_CTL, 16'hffff);
      rd_chk("cap ctl bits", ADR_CAP_CTL, 16'h20e7);
      wr_reg(ADR_CMP_CTL, 16'hffff);
      rd_chk("cmp ctl bits", ADR_CMP_CTL, 16'h200f);
      wr_reg(ADR_CMP_CTL, 16'h0000);
      wr_reg(3'h5, 16'hffff);
      rd_chk("unmapped", 3'h5, 16'h0000);
      t1 <= 16'h1234;
      t2 <= 16'h5678;
      // Capture modes 001 to 101, alternating time bases
      for (int i = 0; i < 5; i++) begin
         wr_reg(ADR_CAP_CTL, {8'h00, 1'(i % 2), 4'h0, 3'(i + 1)});
         c_irqs = 0;
         p.pulse(npul[i]);
         repeat (8) @(posedge clk);
         chk("cap irqs", 16'(ecap[i]), 16'(c_irqs));
         drain((i % 2) ? 16'h5678 : 16'h1234, n);
         chk("captures", 16'(ecap[i]), 16'(n));
      end
      // Overrun with one interrupt per four captures
      wr_reg(ADR_CAP_CTL, 16'h0063);
      c_irqs = 0;
      p.pulse(5);
      repeat (8) @(posedge clk);
      chk("irq per four", 16'h0001, 16'(c_irqs));
      rd_chk("overflow", ADR_CAP_CTL, 16'h007b);
      drain(16'h1234, n);
      chk("queue depth", 16'h0004, 16'(n));
      rd_chk("overflow held", ADR_CAP_CTL, 16'h0073);
      wr_reg(ADR_CAP_CTL, 16'h0000);
      p.pulse(1);
      repeat (8) @(posedge clk);
      rd_chk("capture off", ADR_CAP_CTL, 16'h0000);
      // Wake from sleep
      sleep <= 1'b1;
      wr_reg(ADR_CAP_CTL, 16'h0007);
      wakes = 0;
      p.pulse(1);
      repeat (8) @(posedge clk);
      chk("wakes", 16'h0001, 16'(wakes));
      rd_chk("wake stores none", ADR_CAP_CTL, 16'h0007);
      sleep <= 1'b0;
      wr_reg(ADR_CAP_CTL, 16'h0000);
      // Compare modes over two periods of 32; mode 111 runs 20 clocks, then takes a fault
      wr_reg(ADR_CMP_PRI, 16'h0008);
      wr_reg(ADR_CMP_SEC, 16'h000c);
      rd_chk("primary", ADR_CMP_PRI, 16'h0008);
      for (int i = 0; i < 8; i++) begin
         run <= 1'b0;
         t1 <= 16'h0000;
         t2 <= 16'h0000;
         sel_b <= 1'(cs[i % 7]);
         idle <= (i < 7) && ci[i] != 0;
         wr_reg(ADR_CMP_CTL, (i < 7) ? {2'h0, 1'(ci[i]), 9'h000, 1'(cs[i]), 3'(cm[i])} : 16'h0007);
         repeat (3) @(posedge clk);
         {rises, falls, p_irqs} = '0;
         cnt_en = 1'b1;
         run <= 1'b1;
         if (i == 7) begin
            repeat (20) @(posedge clk);
            p.fault_hit();
            repeat (10) @(posedge clk);
            chk("fault irq", 16'h0001, 16'(p_irqs));
            chk("fault low", 16'h0000, {15'h0, cmp_out});
            rd_chk("fault status", ADR_CMP_CTL, 16'h0017);
            break;
         end
         repeat (64) @(posedge clk);
         run <= 1'b0;
         repeat (3) @(posedge clk);
         cnt_en = 1'b0;
         if (er[i] >= 0) chk("rises", 16'(er[i]), 16'(rises));
         chk("falls", 16'(ef[i]), 16'(falls));
         chk("cmp irqs", 16'(ei[i]), 16'(p_irqs));
         chk("driven", 16'h0000, {15'h0, oe_n});
      end
      cnt_en = 1'b0;
      wr_reg(ADR_CMP_CTL, 16'h0000);
      rd_chk("fault cleared", ADR_CMP_CTL, 16'h0000);
      chk("pin released", 16'h0001, {15'h0, pad});
      report_and_stop();
   end
endmodule

// [tcc_fifo.sv]
// Four-word capture queue held in flip-flops
`timescale 1ns/1ps
module tcc_fifo (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // Fill side
   input  wire logic                      push,
   input  wire logic [tcc_pkg::DATA_W-1:0] wdata,
   // Drain side
   input  wire logic                      pop,
   output logic      [tcc_pkg::DATA_W-1:0] head,
   // Status
   output logic                           full,
   output logic                           empty
);
   import tcc_pkg::*;

   typedef struct packed {
      logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
      logic [1:0]                        wp;
      logic [1:0]                        rp;
      logic [2:0]                        cnt;
   } tcc_fifo_st_t;

   tcc_fifo_st_t st_q;
   tcc_fifo_st_t st_d;

   // Caller never pushes when full nor pops when empty
   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.mem[st_q.wp] = wdata;
         st_d.wp           = st_q.wp + 2'h1;
      end
      if (pop) begin
         st_d.rp = st_q.rp + 2'h1;
      end
      st_d.cnt = st_q.cnt + {2'h0, push} - {2'h0, pop};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign head  = st_q.mem[st_q.rp];
   assign full  = (st_q.cnt == 3'h4);
   assign empty = (st_q.cnt == 3'h0);
endmodule

// [tcc_partner.sv]
// Pin-side model: capture signal source, fault source and compare output load
`timescale 1ns/1ps
module tcc_partner (
   // Clock
   input  wire logic clk,
   // Driven into the block
   output logic      cap_pin,
   output logic      fault_pin,
   // Seen from the block
   input  wire logic cmp_out,
   input  wire logic cmp_oe_n,
   output logic      pad
);
   // ======================================
   // Output load
   // Released pin rises through the board pull-up
   assign pad = cmp_oe_n ? 1'b1 : cmp_out;

   // ======================================
   // Sources
   initial begin
      cap_pin = 1'b0;
      fault_pin = 1'b1;
   end

   // Four clocks high and five low between pulses, at least twice the synchroniser minimum
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk) cap_pin <= 1'b1;
         repeat (4) @(posedge clk);
         cap_pin <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask

   // Fault line pulled low for a few clocks
   task automatic fault_hit();
      @(posedge clk) fault_pin <= 1'b0;
      repeat (6) @(posedge clk);
      fault_pin <= 1'b1;
   endtask
endmodule

// [tcc_pkg.sv]
// Shared constants and types for the timer capture and compare unit
// How it works
// R1: Capture latches selected 16-bit timer count on event
// R2: Capture timer-select bit picks first or second timer
// R3: Modes 001/010/011 capture both/falling/rising edges
// R4: Modes 100/101 capture every 4th/16th rising edge
// R5: Mode 111 only rising-edge interrupt in sleep/idle
// R6: Four-word queue; interrupt after 1-4 captures
// R7: Overflow flag set on capture while queue full
// R8: Buffer-not-empty reads 1 while values remain
// R9: Capture event wakes device from sleep or idle
// R10: Compare timer-select 1 picks second timer
// R11: Compare match changes output, may raise interrupt
// R12: Mode 001 starts low, match forces high
// R13: Mode 010 starts high, match forces low
// R14: Mode 011 keeps level, toggles on each match
// R15: Mode 100 starts low, single pulse, fall interrupt
// R16: Pulse rises on primary, falls on secondary match
// R17: Mode 101 starts low, continuous pulses, fall interrupt
// R18: Mode 110 PWM, fault ignored, no interrupt
// R19: Mode 111 PWM, fault falling edge interrupts
// R20: Fault status bit set by hardware, hardware clears
// R21: Mode 000 disables compare, pin left to GPIO
// R22: Compare stop-in-idle bit halts channel in idle
// R23: Software stops timer while writing compare control
// R24: Capture mode 000 turns capture off
package tcc_pkg;

   // ===========================================================
   // Register indices on the plain port
   localparam logic [2:0] ADR_CAP_CTL = 3'h0;
   localparam logic [2:0] ADR_CAP_BUF = 3'h1;
   localparam logic [2:0] ADR_CMP_CTL = 3'h2;
   localparam logic [2:0] ADR_CMP_PRI = 3'h3;
   localparam logic [2:0] ADR_CMP_SEC = 3'h4;

   // ===========================================================
   // Field positions
   localparam int CAP_SIDL_BIT = 13;
   localparam int CAP_TSEL_BIT = 7;
   localparam int CAP_ICI_LSB  = 5;
   localparam int CAP_OVF_BIT  = 4;
   localparam int CAP_BNE_BIT  = 3;
   localparam int CMP_SIDL_BIT = 13;
   localparam int CMP_FLT_BIT  = 4;
   localparam int CMP_TSEL_BIT = 3;
   localparam int MODE_LSB     = 0;

   // ===========================================================
   // Reset values and counts
   localparam logic [15:0] CTL_RST   = 16'h0000;
   localparam logic [15:0] VAL_RST   = 16'h0000;
   localparam logic [3:0]  PRE4_LAST = 4'h3;
   localparam logic [3:0]  PRE16_LAST = 4'hf;
   localparam int          FIFO_DEPTH = 4;
   localparam int          DATA_W     = 16;

   // ===========================================================
   // Mode encodings
   typedef enum logic [2:0] {
      CAP_OFF = 3'h0, CAP_BOTH = 3'h1, CAP_FALL = 3'h2, CAP_RISE = 3'h3,
      CAP_PRE4 = 3'h4, CAP_PRE16 = 3'h5, CAP_RSVD = 3'h6, CAP_WAKE = 3'h7
   } tcc_cap_mode_t;

   typedef enum logic [2:0] {
      CMP_OFF = 3'h0, CMP_SET_HI = 3'h1, CMP_SET_LO = 3'h2, CMP_TOGGLE = 3'h3,
      CMP_ONE_PULSE = 3'h4, CMP_PULSES = 3'h5, CMP_PWM = 3'h6, CMP_PWM_FLT = 3'h7
   } tcc_cmp_mode_t;

endpackage

// [tcc_sync.sv]
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module tcc_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Pin and conditioned result
   input  wire logic din,
   output logic      lvl,
   output logic      rise,
   output logic      fall
);
   import tcc_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic rise;
      logic fall;
   } tcc_sync_st_t;

   tcc_sync_st_t st_q;
   tcc_sync_st_t st_d;

   // Only stage two reads stage one; level moves once stages two and three agree
   always_comb begin
      st_d      = st_q;
      st_d.s1   = din;
      st_d.s2   = st_q.s1;
      st_d.s3   = st_q.s2;
      st_d.rise = 1'b0;
      st_d.fall = 1'b0;
      if (st_q.s2 == st_q.s3 && st_q.s3 != st_q.lvl) begin
         st_d.lvl  = st_q.s3;
         st_d.rise = st_q.s3;
         st_d.fall = ~st_q.s3;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign lvl  = st_q.lvl;
   assign rise = st_q.rise;
   assign fall = st_q.fall;
endmodule
